// >>> hdl/uifc_consts.vh
// Register offsets, field positions, reset values and timing counts for the UART interrupt and queue control.
`ifndef UIFC_CONSTS_VH
`define UIFC_CONSTS_VH
`define UIFC_OFF_IEN 8'h00
`define UIFC_OFF_IID 8'h04
`define UIFC_OFF_QCTL 8'h08
`define UIFC_OFF_LFMT 8'h0C
`define UIFC_OFF_EFR 8'h10
`define UIFC_OFF_FCTL 8'h14
`define UIFC_OFF_TRG 8'h18
`define UIFC_OFF_STAT 8'h1C
`define UIFC_BIT_QEN 0
`define UIFC_BIT_RXRST 1
`define UIFC_BIT_TXRST 2
`define UIFC_BIT_DMA 3
`define UIFC_BIT_ENH 4
`define UIFC_BIT_SLEEP 4
`define UIFC_BIT_XOFF 5
`define UIFC_BIT_TRGDIR 7
`define UIFC_IEN_RST 8'h00
`define UIFC_LFMT_RST 8'h00
`define UIFC_CODE_LINE 6'h06
`define UIFC_CODE_TOUT 6'h0C
`define UIFC_CODE_RECEIVE_READY_PIN_N 6'h04
`define UIFC_CODE_TRANSMIT_READY_PIN_N 6'h02
`define UIFC_CODE_MODEM 6'h00
`define UIFC_CODE_XOFF 6'h10
`define UIFC_CODE_NONE 6'h01
`define UIFC_TOUT_CHARS 4
`define UIFC_TOUT_BITS 12
`endif

// >>> hdl/uifc_trigger_table.v
// Trigger-level lookup shared by the receive and transmit queues.
`timescale 1ns/1ps
`default_nettype none
module uifc_trigger_table (
  // Selection
  input wire [1:0] tableSel,
  input wire [1:0] rxSel,
  input wire [1:0] txSel,
  input wire [7:0] progRx,
  input wire [7:0] progTx,
  // Levels
  output reg [7:0] rxLevel,
  output reg [7:0] txLevel
);
  always @* begin
    rxLevel = 8'h01;
    txLevel = 8'h01;
    case (tableSel)
      2'b00: begin
        case (rxSel)
          2'b00: rxLevel = 8'h01;
          2'b01: rxLevel = 8'h04;
          2'b10: rxLevel = 8'h08;
          default: rxLevel = 8'h0E;
        endcase
        txLevel = 8'h01;
      end
      2'b01: begin
        case (rxSel)
          2'b00: rxLevel = 8'h08;
          2'b01: rxLevel = 8'h10;
          2'b10: rxLevel = 8'h18;
          default: rxLevel = 8'h1C;
        endcase
        case (txSel)
          2'b00: txLevel = 8'h10;
          2'b01: txLevel = 8'h08;
          2'b10: txLevel = 8'h18;
          default: txLevel = 8'h1E;
        endcase
      end
      2'b10: begin
        case (rxSel)
          2'b00: rxLevel = 8'h08;
          2'b01: rxLevel = 8'h10;
          2'b10: rxLevel = 8'h38;
          default: rxLevel = 8'h3C;
        endcase
        case (txSel)
          2'b00: txLevel = 8'h08;
          2'b01: txLevel = 8'h10;
          2'b10: txLevel = 8'h20;
          default: txLevel = 8'h38;
        endcase
      end
      default: begin
        rxLevel = progRx;
        txLevel = progTx;
      end
    endcase
  end
endmodule // uifc_trigger_table
`default_nettype wire

// >>> hdl/uifc_ctrl.v
// Interrupt identification and queue control for one UART channel, with an AXI4-Lite register slave.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uifc_consts.vh"
module uifc_ctrl #(
  parameter BIT_CYCLES = 16'd16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Serial engine events and levels
  input wire [7:0] rxCount,
  input wire [7:0] txCount,
  input wire rxCharDone,
  input wire txReload,
  input wire [3:0] lineErr,
  input wire [3:0] modemChg,
  input wire stopCharHit,
  input wire startCharHit,
  input wire sleepExit,
  input wire lineStateRead,
  input wire modemStateRead,
  input wire rxHoldRead,
  input wire txHoldWrite,
  // Controls to the serial engine
  output reg rxQueueClr,
  output reg txQueueClr,
  output reg queueEn,
  output reg dmaMode,
  output reg sleepAllow,
  output reg [3:0] charBits,
  output reg [7:0] rxTrigLevel,
  output reg [7:0] txTrigLevel,
  output reg irqPending
);
  // Control registers.
  reg [7:0] ienFf;
  reg [7:0] lfmtFf;
  reg [7:0] efrFf;
  reg [7:0] fctlFf;
  reg [1:0] rxSelFf;
  reg [1:0] txSelFf;
  reg [7:0] progRxFf;
  reg [7:0] progTxFf;
  // Interrupt sources.
  reg lineIrqFf;
  reg toutIrqFf;
  reg txIrqFf;
  reg modemIrqFf;
  reg xoffIrqFf;
  reg wakeFf;
  reg txOverFf;
  reg [15:0] toutCntFf;
  reg [7:0] txCountPrevFf;
  // Bus state.
  reg awHeldFf;
  reg wHeldFf;
  reg [7:0] awAddrFf;
  reg [31:0] wDataFf;
  wire [7:0] rxLvl;
  wire [7:0] txLvl;
  wire enh = efrFf[`UIFC_BIT_ENH];
  wire rxIrq = queueEn ? (rxCount >= rxLvl) : (rxCount != 8'h00);
  // Timeout: 4 chars plus 12 bits, char length = data bits + start + stop.
  wire [15:0] charBitsTot = {12'h000, charBits} + 16'd2;
  wire [31:0] toutProd = (charBitsTot * `UIFC_TOUT_CHARS + `UIFC_TOUT_BITS) * BIT_CYCLES;
  wire [15:0] toutLimit = toutProd[15:0];

  uifc_trigger_table trigTable (
    .tableSel(fctlFf[5:4]),
    .rxSel(rxSelFf),
    .txSel(txSelFf),
    .progRx(progRxFf),
    .progTx(progTxFf),
    .rxLevel(rxLvl),
    .txLevel(txLvl)
  );

  // Priority encoding of the pending source.
  reg [5:0] iidCode;
  always @* begin
    if (lineIrqFf && ienFf[2]) iidCode = `UIFC_CODE_LINE;
    else if (toutIrqFf && ienFf[0]) iidCode = `UIFC_CODE_TOUT;
    else if (rxIrq && ienFf[0]) iidCode = `UIFC_CODE_RECEIVE_READY_PIN_N;
    else if (txIrqFf && ienFf[1]) iidCode = `UIFC_CODE_TRANSMIT_READY_PIN_N;
    else if (modemIrqFf && ienFf[3]) iidCode = `UIFC_CODE_MODEM;
    else if (xoffIrqFf && ienFf[`UIFC_BIT_XOFF]) iidCode = `UIFC_CODE_XOFF;
    else iidCode = `UIFC_CODE_NONE;
  end
  wire [7:0] iidValue = {queueEn, queueEn, iidCode};

  // Bus handshakes.
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire haveAw = awHeldFf || awTake;
  wire haveW = wHeldFf || wTake;
  wire [7:0] wAddr = awHeldFf ? awAddrFf : s_axi_awaddr;
  wire [31:0] wData = wHeldFf ? wDataFf : s_axi_wdata;
  wire doWrite = haveAw && haveW && !s_axi_bvalid;
  wire wr0 = doWrite && s_axi_wstrb[0];
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire iidRead = arTake && (s_axi_araddr == `UIFC_OFF_IID);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
      awHeldFf <= 1'b0;
      wHeldFf <= 1'b0;
      awAddrFf <= 8'h00;
      wDataFf <= 32'h00000000;
    end else begin
      if (awTake) awAddrFf <= s_axi_awaddr;
      if (wTake) wDataFf <= s_axi_wdata;
      if (doWrite) begin
        awHeldFf <= 1'b0;
        wHeldFf <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wAddr[1:0] == 2'b00 && wAddr <= `UIFC_OFF_TRG && wAddr != `UIFC_OFF_IID) ? 2'b00 : 2'b10;
      end else begin
        if (awTake) begin
          awHeldFf <= 1'b1;
          s_axi_awready <= 1'b0;
        end
        if (wTake) begin
          wHeldFf <= 1'b1;
          s_axi_wready <= 1'b0;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `UIFC_OFF_IEN: s_axi_rdata <= {24'h000000, ienFf};
          `UIFC_OFF_IID: s_axi_rdata <= {24'h000000, iidValue};
          `UIFC_OFF_LFMT: s_axi_rdata <= {24'h000000, lfmtFf};
          `UIFC_OFF_EFR: s_axi_rdata <= {24'h000000, efrFf};
          `UIFC_OFF_FCTL: s_axi_rdata <= {24'h000000, fctlFf};
          `UIFC_OFF_STAT: s_axi_rdata <= {16'h0000, rxCount, txCount};
          `UIFC_OFF_QCTL: s_axi_rdata <= 32'h00000000;
          `UIFC_OFF_TRG: s_axi_rdata <= 32'h00000000;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Register writes and queue control.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ienFf <= `UIFC_IEN_RST;
      lfmtFf <= `UIFC_LFMT_RST;
      efrFf <= 8'h00;
      fctlFf <= 8'h00;
      rxSelFf <= 2'b00;
      txSelFf <= 2'b00;
      progRxFf <= 8'h01;
      progTxFf <= 8'h01;
      queueEn <= 1'b0;
      dmaMode <= 1'b0;
      rxQueueClr <= 1'b0;
      txQueueClr <= 1'b0;
    end else begin
      rxQueueClr <= 1'b0;
      txQueueClr <= 1'b0;
      if (wr0) begin
        case (wAddr)
          `UIFC_OFF_IEN: begin
            ienFf[3:0] <= wData[3:0];
            if (enh) ienFf[7:4] <= wData[7:4];
          end
          `UIFC_OFF_LFMT: lfmtFf <= wData[7:0];
          `UIFC_OFF_EFR: efrFf <= wData[7:0];
          `UIFC_OFF_FCTL: fctlFf <= wData[7:0];
          `UIFC_OFF_TRG: begin
            if (fctlFf[`UIFC_BIT_TRGDIR]) progTxFf <= wData[7:0];
            else progRxFf <= wData[7:0];
          end
          `UIFC_OFF_QCTL: begin
            queueEn <= wData[`UIFC_BIT_QEN];
            if (wData[`UIFC_BIT_QEN]) begin
              rxQueueClr <= wData[`UIFC_BIT_RXRST];
              txQueueClr <= wData[`UIFC_BIT_TXRST];
              dmaMode <= wData[`UIFC_BIT_DMA];
              rxSelFf <= wData[7:6];
              if (enh) txSelFf <= wData[5:4];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Interrupt source flags; a set in the same cycle as a clear wins, except the timeout flag, where a data read wins.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineIrqFf <= 1'b0;
      toutIrqFf <= 1'b0;
      txIrqFf <= 1'b0;
      modemIrqFf <= 1'b0;
      xoffIrqFf <= 1'b0;
      wakeFf <= 1'b0;
      txOverFf <= 1'b0;
      toutCntFf <= 16'h0000;
      txCountPrevFf <= 8'h00;
    end else begin
      txCountPrevFf <= txCount;
      if (|lineErr) lineIrqFf <= 1'b1;
      else if (lineStateRead) lineIrqFf <= 1'b0;
      if (|modemChg) modemIrqFf <= 1'b1;
      else if (modemStateRead) modemIrqFf <= 1'b0;
      // Timer restarts on each received char or data read; runs only with data waiting.
      if (rxCharDone || rxHoldRead || rxCount == 8'h00) toutCntFf <= 16'h0000;
      else if (toutCntFf < toutLimit) toutCntFf <= toutCntFf + 16'd1;
      if (toutCntFf == toutLimit - 16'd1 && !rxCharDone && !rxHoldRead && rxCount != 8'h00)
        toutIrqFf <= 1'b1;
      else if (rxHoldRead) toutIrqFf <= 1'b0;
      if (txReload) txOverFf <= (txCount > txLvl);
      if ((queueEn && txOverFf && txCount < txLvl && txCountPrevFf >= txLvl) ||
          (txCount == 8'h00 && txCountPrevFf != 8'h00)) txIrqFf <= 1'b1;
      else if (iidRead && iidCode == `UIFC_CODE_TRANSMIT_READY_PIN_N) txIrqFf <= 1'b0;
      else if (txHoldWrite) txIrqFf <= 1'b0;
      if (stopCharHit) xoffIrqFf <= 1'b1;
      else if ((iidRead && iidCode == `UIFC_CODE_XOFF) || startCharHit || rxCharDone) xoffIrqFf <= 1'b0;
      if (sleepExit) wakeFf <= 1'b1;
      else if (iidRead) wakeFf <= 1'b0;
    end
  end

  // Registered outputs to the serial engine.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepAllow <= 1'b0;
      charBits <= 4'h5;
      rxTrigLevel <= 8'h01;
      txTrigLevel <= 8'h01;
      irqPending <= 1'b0;
    end else begin
      sleepAllow <= ienFf[`UIFC_BIT_SLEEP];
      charBits <= 4'h5 + {2'b00, lfmtFf[1:0]};
      rxTrigLevel <= rxLvl;
      txTrigLevel <= txLvl;
      irqPending <= (iidCode != `UIFC_CODE_NONE);
    end
  end
endmodule // uifc_ctrl
`default_nettype wire

// >>> verif/uifc_ctrl_sva.sv
// Assertion checker for the interrupt and queue control block.
`timescale 1ns/1ps
`default_nettype none
module uifc_ctrl_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Engine controls
  input wire logic rxQueueClr,
  input wire logic txQueueClr,
  input wire logic queueEn,
  input wire logic [3:0] charBits
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence wTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wTake |=> s_axi_bvalid)
    else $error("write response missing");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (rTake |=> s_axi_rvalid)
    else $error("read response missing");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_rx_clear_pulse: assert property (rxQueueClr |=> !rxQueueClr)
    else $error("receive clear longer than one cycle");
  a_tx_clear_pulse: assert property (txQueueClr |=> !txQueueClr)
    else $error("transmit clear longer than one cycle");
  a_clear_enabled: assert property (rxQueueClr || txQueueClr |-> queueEn)
    else $error("queue clear with queues off");
  a_char_length: assert property (charBits >= 4'h5 && charBits <= 4'h8)
    else $error("character length out of range");
endmodule // uifc_ctrl_sva
bind uifc_ctrl uifc_ctrl_sva uifc_ctrl_sva_i (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .rxQueueClr,
  .txQueueClr, .queueEn, .charBits);
`default_nettype wire

// >>> verif/uifc_engine_model.sv
// Behavioural serial engine holding the queue fill levels.
`timescale 1ns/1ps
`default_nettype none
module uifc_engine_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bench load of fill levels
  input wire logic setStb,
  input wire logic [7:0] setRx,
  input wire logic [7:0] setTx,
  // Controls from the block
  input wire logic rxQueueClr,
  input wire logic txQueueClr,
  // Fill levels
  output logic [7:0] rxCount,
  output logic [7:0] txCount
);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCount <= 8'h00;
      txCount <= 8'h00;
    end else if (setStb) begin
      rxCount <= setRx;
      txCount <= setTx;
    end else begin
      if (rxQueueClr) rxCount <= 8'h00;
      if (txQueueClr) txCount <= 8'h00;
    end
  end
endmodule // uifc_engine_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the interrupt and queue control block.
`timescale 1ns/1ps
`default_nettype none
`include "uifc_consts.vh"
module testbench;
  logic sys_clk = 1'b0, rst_n = 1'b0, setStb = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, setRx = 8'h00, setTx = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, rdv = 32'h0, s_axi_rdata;
  logic [8:0] ev = 9'h000;
  logic [3:0] lineErr = 4'h0, modemChg = 4'h0, charBits;
  logic [7:0] rxCount, txCount, rxTrigLevel, txTrigLevel;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rxQueueClr, txQueueClr, queueEn, dmaMode, sleepAllow, irqPending;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0, total_checks = 0, t, v;
  int rxT[12] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60};
  int txT[12] = '{1, 1, 1, 1, 16, 8, 24, 30, 8, 16, 32, 56};
  always #20 sys_clk = ~sys_clk;
  uifc_ctrl #(.BIT_CYCLES(16'd16)) uifc_ctrl_i (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'b1), .rxCount, .txCount, .rxCharDone(ev[0]), .txReload(ev[1]), .lineErr,
    .modemChg, .stopCharHit(ev[2]), .startCharHit(ev[3]), .sleepExit(ev[4]), .lineStateRead(ev[5]),
    .modemStateRead(ev[6]), .rxHoldRead(ev[7]), .txHoldWrite(ev[8]), .rxQueueClr, .txQueueClr, .queueEn,
    .dmaMode, .sleepAllow, .charBits, .rxTrigLevel, .txTrigLevel, .irqPending);
  uifc_engine_model uifc_engine_model_i (.sys_clk, .rst_n, .setStb, .setRx, .setTx, .rxQueueClr, .txQueueClr,
    .rxCount, .txCount);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (!s_axi_bvalid && k < 40);
    if (!s_axi_bvalid) begin
      errors++;
      end_sim();
    end
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = 2'b00);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!s_axi_rvalid && k < 40);
    if (!s_axi_rvalid) begin
      errors++;
      end_sim();
    end
    rdv = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev[b] <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic setq(input logic [7:0] r, input logic [7:0] x);
    setRx <= r;
    setTx <= x;
    setStb <= 1'b1;
    @(posedge sys_clk);
    setStb <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    v = $urandom(32'h6be4);
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rc(`UIFC_OFF_IEN, 32'h0);
    rc(`UIFC_OFF_LFMT, 32'h0);
    rc(`UIFC_OFF_IID, 32'h01);
    rd(8'h20, 2'b10);
    wr(`UIFC_OFF_IID, 32'h0, 2'b10);
    for (t = 0; t < 4; t++) begin
      wr(`UIFC_OFF_LFMT, t);
      chk({28'h0, charBits}, 5 + t);
      rc(`UIFC_OFF_LFMT, t);
    end
    wr(`UIFC_OFF_IEN, 32'h30);
    chk({31'h0, sleepAllow}, 32'h0);
    rc(`UIFC_OFF_IEN, 32'h0);
    wr(`UIFC_OFF_EFR, 32'h10);
    wr(`UIFC_OFF_IEN, 32'h30);
    chk({31'h0, sleepAllow}, 32'h1);
    rc(`UIFC_OFF_IEN, 32'h30);
    wr(`UIFC_OFF_QCTL, 32'h08);
    chk({30'h0, queueEn, dmaMode}, 32'h0);
    wr(`UIFC_OFF_QCTL, 32'h09);
    chk({30'h0, queueEn, dmaMode}, 32'h3);
    rc(`UIFC_OFF_IID, 32'hC1);
    for (t = 0; t < 12; t++) begin
      wr(`UIFC_OFF_FCTL, (t / 4) << 4);
      wr(`UIFC_OFF_QCTL, (t % 4) * 32'h50 + 1);
      chk({16'h0, rxTrigLevel, txTrigLevel}, rxT[t] * 256 + txT[t]);
    end
    v = $urandom_range(63, 1);
    wr(`UIFC_OFF_FCTL, 32'h30);
    wr(`UIFC_OFF_TRG, v);
    wr(`UIFC_OFF_FCTL, 32'hB0);
    wr(`UIFC_OFF_TRG, v + 1);
    chk({16'h0, rxTrigLevel, txTrigLevel}, v * 257 + 1);
    wr(`UIFC_OFF_FCTL, 32'h0);
    setq(8'h05, 8'h07);
    wr(`UIFC_OFF_QCTL, 32'h03);
    rc(`UIFC_OFF_STAT, 32'h0007);
    wr(`UIFC_OFF_QCTL, 32'h05);
    rc(`UIFC_OFF_STAT, 32'h0000);
    wr(`UIFC_OFF_QCTL, 32'h41);
    wr(`UIFC_OFF_IEN, 32'h2D);
    setq(8'h04, 8'h00);
    lineErr <= 4'h1 << $urandom_range(3, 0);
    modemChg <= 4'h1 << $urandom_range(3, 0);
    @(posedge sys_clk);
    lineErr <= 4'h0;
    modemChg <= 4'h0;
    @(posedge sys_clk);
    rc(`UIFC_OFF_IID, 32'hC6);
    chk({31'h0, irqPending}, 32'h1);
    pulse(5);
    rc(`UIFC_OFF_IID, 32'hC4);
    setq(8'h00, 8'h00);
    rc(`UIFC_OFF_IID, 32'hC0);
    pulse(6);
    rc(`UIFC_OFF_IID, 32'hC1);
    pulse(2);
    rc(`UIFC_OFF_IID, 32'hD0);
    rc(`UIFC_OFF_IID, 32'hC1);
    pulse(4);
    rc(`UIFC_OFF_IID, 32'hC1);
    setq(8'h02, 8'h00);
    for (t = 0; t < 600 && rdv !== 32'hCC; t++) rd(`UIFC_OFF_IID);
    chk(rdv, 32'hCC);
    pulse(7);
    rc(`UIFC_OFF_IID, 32'hC1);
    setq(8'h00, 8'h02);
    wr(`UIFC_OFF_IEN, 32'h2F);
    setq(8'h00, 8'h00);
    rc(`UIFC_OFF_IID, 32'hC2);
    rc(`UIFC_OFF_IID, 32'hC1);
    setq(8'h00, 8'h03);
    setq(8'h00, 8'h00);
    pulse(8);
    rc(`UIFC_OFF_IID, 32'hC1);
    pulse(2);
    pulse(3);
    rc(`UIFC_OFF_IID, 32'hC1);
    pulse(2);
    pulse(0);
    rc(`UIFC_OFF_IID, 32'hC1);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
